// file: shared/reset_strap_wake_control_defs.svh
`ifndef RESET_STRAP_WAKE_CONTROL_DEFS_SVH
`define RESET_STRAP_WAKE_CONTROL_DEFS_SVH
// ==========================================
// Register byte offsets
`define OFS_CTRL 8'h00
`define OFS_STATUS 8'h04
`define OFS_IRQ_STATUS 8'h08
`define OFS_IRQ_CLEAR 8'h0C
`define OFS_IRQ_ENABLE 8'h10
`define OFS_BYTE_TEST 8'h14
// ==========================================
// Control field positions
`define CTRL_WAKE_EN 0
`define CTRL_POLARITY 1
`define CTRL_OPEN_DRAIN 2
`define CTRL_SLEEP 3
// ==========================================
// Event bit positions
`define IRQ_WAKE_EVENT 0
`define IRQ_WOKE_UP 1
// ==========================================
// Reset values
`define CTRL_RST 3'h0
`define IRQ_RST 2'h0
`define STRAP_RST 1'b1
// ==========================================
// Clock figures
`define REF_CLK_MHZ 25
`define CORE_CLK_MHZ 200
`endif

// file: shared/reset_strap_wake_control_pkg.sv
// ==========================================
// Types shared by the wake control block
package reset_strap_wake_control_pkg;
  // Power state, one-hot
  typedef enum logic [1:0] {
    ST_RUN = 2'b01,
    ST_SLEEP = 2'b10
  } power_state_t;
  // Wake pin configuration
  typedef struct packed {
    logic open_drain; // Drive style
    logic polarity; // 1 = active high
    logic wake_en; // Pin reports events
  } wake_ctrl_t;
  // Sticky event bits
  typedef struct packed {
    logic woke_up; // Left power saving
    logic wake_event; // Event seen
  } irq_bits_t;
endpackage

// file: rtl/reset_strap_wake_control.sv
// The implementer's own choices: the Avalon-MM slave port and the register addresses.
`timescale 1ns/1ps
// ==========================================
`include "reset_strap_wake_control_defs.svh"

module reset_strap_wake_control
  import reset_strap_wake_control_pkg::*;
#(
  // Arbitrary pattern, no meaning
  parameter logic [31:0] BYTE_TEST_VALUE = 32'h0123_4567
) (
  input wire logic core_clk_i, // Core clock
  input wire logic reset_i, // Power-on reset
  input wire logic hard_reset_in_n_i, // Hard reset pin
  input wire logic ref_clock_in_i, // Reference pin
  output logic ref_crystal_out_o, // Crystal drive
  input wire logic speed_strap_i, // Speed strap pin
  input wire logic crossover_auto_enable_i, // Crossover pin
  input wire logic chip_select_n_i, // Host chip select
  input wire logic write_strobe_n_i, // Host write strobe
  input wire logic wake_event_i, // Internal wake event
  input wire logic [7:0] avs_address_i, // Byte address
  input wire logic avs_read_i, // Read request
  input wire logic avs_write_i, // Write request
  input wire logic [3:0] avs_byteenable_i, // Byte lanes
  input wire logic [31:0] avs_writedata_i, // Write data
  output logic [31:0] avs_readdata_o, // Read data
  output logic avs_waitrequest_o, // Stall
  output logic wake_indicator_out_o, // Wake pin level
  output logic wake_indicator_out_oe_o, // Wake pin enable
  output logic crossover_auto_enable_o, // Crossover on
  output logic default_speed_100_o, // Default 100M
  output logic default_autoneg_o, // Default autoneg
  output logic default_full_duplex_o, // Default duplex
  output logic sleep_o, // In power saving
  output logic device_reset_o, // Internal reset
  output logic irq_o // Interrupt level
);

  // ==========================================
  // Reference clock
  // The core clock is made from this reference outside
  assign ref_crystal_out_o = ~ref_clock_in_i;

  // ==========================================
  // Reset combination
  // Floating pin idles high, so reset_i alone acts
  wire raw_rst = reset_i | ~hard_reset_in_n_i;
  logic [1:0] rst_pipe_r; // Release synchroniser
  wire core_rst = rst_pipe_r[1]; // Internal reset

  // Assert at once, release on a clock edge
  always_ff @(posedge core_clk_i or posedge raw_rst) begin
    if (raw_rst) begin
      rst_pipe_r <= 2'b11;
    end else begin
      rst_pipe_r <= {rst_pipe_r[0], 1'b0};
    end
  end
  assign device_reset_o = core_rst;

  // ==========================================
  // Pin synchronisers
  // Kept live during hard reset so straps settle
  logic speed_meta_r, speed_sync_r; // Strap sync
  logic xover_meta_r, xover_sync_r; // Crossover sync
  logic cs_meta_r, cs_sync_r; // Chip select sync
  logic wr_meta_r, wr_sync_r; // Strobe sync

  // Two flops per pin
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      speed_meta_r <= `STRAP_RST;
      speed_sync_r <= `STRAP_RST;
      xover_meta_r <= 1'b0;
      xover_sync_r <= 1'b0;
      cs_meta_r <= 1'b1;
      cs_sync_r <= 1'b1;
      wr_meta_r <= 1'b1;
      wr_sync_r <= 1'b1;
    end else begin
      speed_meta_r <= speed_strap_i;
      speed_sync_r <= speed_meta_r;
      xover_meta_r <= crossover_auto_enable_i;
      xover_sync_r <= xover_meta_r;
      cs_meta_r <= chip_select_n_i;
      cs_sync_r <= cs_meta_r;
      wr_meta_r <= write_strobe_n_i;
      wr_sync_r <= wr_meta_r;
    end
  end
  // Pull-down on the pin makes floating read as off
  assign crossover_auto_enable_o = xover_sync_r;

  // ==========================================
  // Strap capture
  logic strap_done_r; // Strap already taken
  logic speed_strap_r; // Latched speed strap

  // Taken once, on the first cycle out of reset
  always_ff @(posedge core_clk_i or posedge core_rst) begin
    if (core_rst) begin
      strap_done_r <= 1'b0;
      speed_strap_r <= `STRAP_RST;
    end else if (!strap_done_r) begin
      strap_done_r <= 1'b1;
      speed_strap_r <= speed_sync_r;
    end
  end
  assign default_speed_100_o = speed_strap_r;
  assign default_autoneg_o = speed_strap_r;
  assign default_full_duplex_o = 1'b0;

  // ==========================================
  // Bus slave handshake
  // One stall cycle per access, answer registered
  logic ack_r; // Answer cycle
  wire bus_req = avs_read_i | avs_write_i;
  wire wr_take = avs_write_i & ack_r;
  wire rd_take = avs_read_i & ack_r;
  assign avs_waitrequest_o = bus_req & ~ack_r;

  // Address decode
  wire sel_ctrl = avs_address_i == `OFS_CTRL;
  wire sel_status = avs_address_i == `OFS_STATUS;
  wire sel_irq = avs_address_i == `OFS_IRQ_STATUS;
  wire sel_clear = avs_address_i == `OFS_IRQ_CLEAR;
  wire sel_enable = avs_address_i == `OFS_IRQ_ENABLE;
  wire sel_test = avs_address_i == `OFS_BYTE_TEST;

  // ==========================================
  // State and register storage
  power_state_t state_r, state_nxt; // Power state
  wake_ctrl_t ctrl_r; // Wake pin setup
  irq_bits_t irq_status_r, irq_set; // Sticky events
  irq_bits_t irq_en_r; // Event enables
  logic read_seen_r; // First read done
  logic wake_pend_r; // Wake request held
  logic pin_prev_r; // Previous pin cycle
  logic [31:0] rd_mux; // Read selection
  wire sleeping = state_r == ST_SLEEP;

  // Writes count only after a read and while awake
  wire wr_ok = wr_take & read_seen_r & ~sleeping & avs_byteenable_i[0];
  wire [3:0] wd = avs_writedata_i[3:0];
  wire sleep_req = wr_ok & sel_ctrl & wd[`CTRL_SLEEP];

  // Pin write cycle: select and strobe low together
  wire pin_cycle = ~cs_sync_r & ~wr_sync_r;
  wire pin_start = pin_cycle & ~pin_prev_r;
  // Any data, any address; software aims at byte test
  wire host_write = wr_take | pin_start;
  wire leaving = sleeping & host_write;

  // Event sources for the sticky bits
  assign irq_set.wake_event = wake_event_i;
  assign irq_set.woke_up = leaving;

  // Read data selection, unmapped reads give zero
  wire [31:0] status_word = {27'h000_0000, wake_pend_r, read_seen_r,
                             xover_sync_r, speed_strap_r, sleeping};
  assign rd_mux = sel_ctrl ? {29'h0000_0000, ctrl_r} :
                  sel_status ? status_word :
                  sel_irq ? {30'h0000_0000, irq_status_r} :
                  sel_enable ? {30'h0000_0000, irq_en_r} :
                  sel_test ? BYTE_TEST_VALUE : 32'h0000_0000;

  // Next power state
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_RUN: begin
        if (sleep_req) begin
          state_nxt = ST_SLEEP;
        end
      end
      ST_SLEEP: begin
        // Wake events alone leave us asleep
        if (host_write) begin
          state_nxt = ST_RUN;
        end
      end
      default: begin
        state_nxt = ST_RUN;
      end
    endcase
  end
  assign sleep_o = sleeping;

  // Handshake and read data
  always_ff @(posedge core_clk_i or posedge core_rst) begin
    if (core_rst) begin
      ack_r <= 1'b0;
      avs_readdata_o <= 32'h0000_0000;
    end else begin
      ack_r <= bus_req & ~ack_r;
      if (bus_req & ~ack_r) begin
        avs_readdata_o <= rd_mux;
      end
    end
  end

  // Power state and read tracking
  always_ff @(posedge core_clk_i or posedge core_rst) begin
    if (core_rst) begin
      state_r <= ST_RUN;
      read_seen_r <= 1'b0;
      pin_prev_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      pin_prev_r <= pin_cycle;
      // Returning from power saving needs a new read
      if (leaving) begin
        read_seen_r <= 1'b0;
      end else if (rd_take) begin
        read_seen_r <= 1'b1;
      end
    end
  end

  // Configuration and event registers
  always_ff @(posedge core_clk_i or posedge core_rst) begin
    if (core_rst) begin
      ctrl_r <= `CTRL_RST;
      irq_en_r <= `IRQ_RST;
      irq_status_r <= `IRQ_RST;
    end else begin
      if (wr_ok & sel_ctrl) begin
        ctrl_r <= wd[2:0];
      end
      if (wr_ok & sel_enable) begin
        irq_en_r <= wd[1:0];
      end
      // Set wins over a clear in the same cycle
      if (wr_ok & sel_clear) begin
        irq_status_r <= (irq_status_r & ~wd[1:0]) | irq_set;
      end else begin
        irq_status_r <= irq_status_r | irq_set;
      end
    end
  end
  assign irq_o = |(irq_status_r & irq_en_r);

  // ==========================================
  // Wake indicator
  // Held until we wake or software disables it
  wire pin_level = wake_pend_r ^ ~ctrl_r.polarity;

  always_ff @(posedge core_clk_i or posedge core_rst) begin
    if (core_rst) begin
      wake_pend_r <= 1'b0;
      wake_indicator_out_o <= 1'b0;
      wake_indicator_out_oe_o <= 1'b0;
    end else begin
      // A new event beats the clear on leaving
      if (wake_event_i & ctrl_r.wake_en) begin
        wake_pend_r <= 1'b1;
      end else if (leaving | ~ctrl_r.wake_en) begin
        wake_pend_r <= 1'b0;
      end
      // Open drain can only pull low
      if (ctrl_r.open_drain) begin
        wake_indicator_out_o <= 1'b0;
        wake_indicator_out_oe_o <= ~pin_level;
      end else begin
        wake_indicator_out_o <= pin_level;
        wake_indicator_out_oe_o <= 1'b1;
      end
    end
  end

  // ==========================================
  // Checks
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (core_rst);

  sequence s_wake;
    sleeping ##0 host_write;
  endsequence

  sequence s_xover_high;
    crossover_auto_enable_i [*3];
  endsequence

  a_reset_holds: assert property (@(posedge core_clk_i) disable iff (reset_i)
    !hard_reset_in_n_i |=> device_reset_o && sleep_o == 1'b0)
    else $error("hard reset not applied");
  a_wake_on_write: assert property (s_wake |=> !sleeping && !read_seen_r)
    else $error("host write did not wake");
  a_event_no_wake: assert property (sleeping && !host_write |=> sleeping)
    else $error("left sleep without host write");
  a_early_write_void: assert property (
    wr_take && !read_seen_r |=> $stable(ctrl_r) && $stable(irq_en_r))
    else $error("write before read took effect");
  a_wake_pend_set: assert property (
    wake_event_i && ctrl_r.wake_en |=> wake_pend_r ##1 (wake_indicator_out_o == pin_level
    || ctrl_r.open_drain))
    else $error("wake request not raised");
  // The first edge after release still shows the reset pin flops, so it is skipped
  a_pin_push_pull: assert property (!$past(core_rst) && !$past(ctrl_r.open_drain) |->
    wake_indicator_out_oe_o && wake_indicator_out_o ==
    ($past(wake_pend_r) ^ ~$past(ctrl_r.polarity)))
    else $error("push-pull level wrong");
  a_pin_open_drain: assert property ($past(ctrl_r.open_drain) |->
    !wake_indicator_out_o && wake_indicator_out_oe_o ==
    !($past(wake_pend_r) ^ ~$past(ctrl_r.polarity)))
    else $error("open-drain drive wrong");
  a_xover_follow: assert property (s_xover_high |=> crossover_auto_enable_o)
    else $error("crossover not enabled");
  a_strap_hold: assert property (strap_done_r |=> $stable(speed_strap_r))
    else $error("strap changed after capture");
  a_strap_map: assert property (default_autoneg_o == default_speed_100_o
    && !default_full_duplex_o)
    else $error("default settings mismatch");
  a_bus_answer: assert property (bus_req && !ack_r |=> !avs_waitrequest_o
    && avs_readdata_o == $past(rd_mux))
    else $error("bus answer late");

endmodule // reset_strap_wake_control

// file: dv/host_pin_model.sv
`timescale 1ns/1ps
// ==========================================
// Host CPU seen from its bus pins
module host_pin_model (
  input wire logic clk_i, // Core clock
  output logic chip_select_n_o, // Chip select pin
  output logic write_strobe_n_o // Write strobe pin
);
  // Idle: both strobes released high
  initial begin
    chip_select_n_o = 1'b1;
    write_strobe_n_o = 1'b1;
  end
  // Pin write cycle aimed at the byte test register
  // Caller reads first after reset or wake before trusting writes
  // Held 4 cycles so the 2-flop synchroniser surely sees it
  task automatic pin_write();
    @(posedge clk_i);
    chip_select_n_o <= 1'b0;
    write_strobe_n_o <= 1'b0;
    repeat (4) @(posedge clk_i);
    chip_select_n_o <= 1'b1;
    write_strobe_n_o <= 1'b1;
  endtask
endmodule // host_pin_model

// file: dv/test_reset_strap_wake_control.sv
`timescale 1ns/1ps
`include "reset_strap_wake_control_defs.svh"
// ==========================================
// Self-checking bench
module test_reset_strap_wake_control;
  import reset_strap_wake_control_pkg::*;
  logic clk, rst, hard_n, refc, strap, xover, evt, rd, wr;
  logic [7:0] adr;
  logic [3:0] be;
  logic [31:0] wdat, rdat, got;
  logic wreq, wout, woe, xo, spd, an, fd, slp, drst, irq, cs_n, wr_n, xtal;
  int mismatches = 0;
  int checked = 0;
  // ==========================================
  // Clock, 5 ns period
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  host_pin_model host (.clk_i(clk), .chip_select_n_o(cs_n), .write_strobe_n_o(wr_n));
  reset_strap_wake_control dut (
    .core_clk_i(clk), .reset_i(rst), .hard_reset_in_n_i(hard_n), .ref_clock_in_i(refc),
    .ref_crystal_out_o(xtal), .speed_strap_i(strap), .crossover_auto_enable_i(xover),
    .chip_select_n_i(cs_n), .write_strobe_n_i(wr_n), .wake_event_i(evt),
    .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr), .avs_byteenable_i(be),
    .avs_writedata_i(wdat), .avs_readdata_o(rdat), .avs_waitrequest_o(wreq),
    .wake_indicator_out_o(wout), .wake_indicator_out_oe_o(woe),
    .crossover_auto_enable_o(xo), .default_speed_100_o(spd), .default_autoneg_o(an),
    .default_full_duplex_o(fd), .sleep_o(slp), .device_reset_o(drst), .irq_o(irq));
  // ==========================================
  // Verdict, the only exit
  task automatic tally_and_finish();
    if (mismatches == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // Compare seen against expected
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %0t %s got %h want %h", $time, what, seen, exp);
    end
  endtask
  // Wait, bounded, for the rising edge that samples waitrequest low; data taken there
  task automatic wait_ack();
    int n;
    n = 0;
    @(posedge clk);
    while (wreq !== 1'b0) begin
      n++;
      if (n > 50) begin
        chk(1, 0, "bus timeout");
        tally_and_finish();
      end
      @(posedge clk);
    end
    got = rdat;
  endtask
  // Avalon read; data taken at the acking edge
  task automatic bus_rd(input logic [7:0] a, output logic [31:0] d);
    adr <= a;
    rd <= 1'b1;
    wait_ack();
    d = got;
    rd <= 1'b0;
    @(posedge clk);
  endtask
  // Avalon write
  task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
    adr <= a;
    wdat <= d;
    wr <= 1'b1;
    wait_ack();
    wr <= 1'b0;
    @(posedge clk);
  endtask
  // Read and compare
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input string what);
    logic [31:0] v;
    bus_rd(a, v);
    chk(v, e, what);
  endtask
  // Bounded wait for internal reset to let go
  task automatic wait_run();
    int n;
    n = 0;
    while (drst !== 1'b0) begin
      n++;
      if (n > 20) begin
        chk(1, 0, "reset stuck");
        tally_and_finish();
      end
      @(posedge clk);
    end
    repeat (2) @(posedge clk);
  endtask
  // One-cycle wake event pulse
  task automatic pulse_evt();
    @(posedge clk);
    evt <= 1'b1;
    @(posedge clk);
    evt <= 1'b0;
    repeat (4) @(posedge clk);
  endtask
  // ==========================================
  // Main sequence
  initial begin
    rst = 1'b1;
    hard_n = 1'b1; // Pin left floating, pull-up level
    refc = 1'b0;
    strap = 1'b0;
    xover = 1'b0; // Floating, pull-down level
    evt = 1'b0;
    rd = 1'b0;
    wr = 1'b0;
    adr = 8'h00;
    be = 4'hf;
    wdat = 32'h0000_0000;
    repeat (12) @(posedge clk);
    chk(drst, 1, "reset held");
    rst <= 1'b0;
    wait_run();
    chk({spd, an, fd}, 3'h0, "strap 0 defaults");
    chk({woe, wout}, 2'h3, "wake pin idle");
    chk(xo, 0, "crossover off");
    xover <= 1'b1;
    refc <= 1'b1;
    repeat (4) @(posedge clk);
    chk(xo, 1, "crossover on");
    chk(xtal, 0, "crystal drive");
    // Writes before the first read are dropped
    bus_wr(`OFS_CTRL, 32'h0000_0001);
    rd_chk(`OFS_CTRL, 32'h0000_0000, "early write");
    bus_wr(`OFS_CTRL, 32'h0000_0001);
    rd_chk(`OFS_CTRL, 32'h0000_0001, "ctrl write");
    rd_chk(8'h40, 32'h0000_0000, "unmapped");
    rd_chk(`OFS_BYTE_TEST, 32'h0123_4567, "byte test");
    bus_wr(`OFS_IRQ_ENABLE, 32'h0000_0003);
    // Event asserts the pin, active low push-pull
    pulse_evt();
    chk({woe, wout, irq}, 3'h5, "pin active low");
    bus_wr(`OFS_IRQ_CLEAR, 32'h0000_0001);
    chk(irq, 0, "irq cleared");
    bus_wr(`OFS_CTRL, 32'h0000_0003);
    repeat (3) @(posedge clk);
    chk({woe, wout}, 2'h3, "pin active high");
    bus_wr(`OFS_CTRL, 32'h0000_0005);
    repeat (3) @(posedge clk);
    chk({woe, wout}, 2'h2, "open drain low");
    // Sleep; the event must not wake
    bus_wr(`OFS_CTRL, 32'h0000_0009);
    chk(slp, 1, "asleep");
    pulse_evt();
    chk({slp, woe, wout}, 3'h6, "event keeps sleep");
    host.pin_write();
    repeat (4) @(posedge clk);
    chk({slp, woe, wout}, 3'h3, "pin write wakes");
    bus_wr(`OFS_CTRL, 32'h0000_0000);
    rd_chk(`OFS_CTRL, 32'h0000_0001, "write after wake");
    rd_chk(`OFS_IRQ_STATUS, 32'h0000_0003, "sticky events");
    // Bus write of any value wakes too
    bus_wr(`OFS_CTRL, 32'h0000_0008);
    chk(slp, 1, "asleep again");
    bus_wr(`OFS_BYTE_TEST, 32'h0000_0000);
    repeat (2) @(posedge clk);
    chk(slp, 0, "bus write wakes");
    // Hard reset, strap relatched high
    @(posedge clk);
    hard_n <= 1'b0;
    strap <= 1'b1;
    repeat (3) @(posedge clk);
    chk({drst, woe, slp, irq}, 4'h8, "hard reset");
    hard_n <= 1'b1;
    @(posedge clk);
    wait_run();
    chk({spd, an, fd}, 3'h6, "strap 1 defaults");
    rd_chk(`OFS_CTRL, 32'h0000_0000, "ctrl after reset");
    rd_chk(`OFS_STATUS, 32'h0000_000E, "status word");
    // Lane 0 disabled, so the write is dropped
    be <= 4'he;
    bus_wr(`OFS_CTRL, 32'h0000_0001);
    be <= 4'hf;
    rd_chk(`OFS_CTRL, 32'h0000_0000, "lane 0 off");
    tally_and_finish();
  end
endmodule // test_reset_strap_wake_control
